// ==== verilog/analog_pin_pkg.sv ====
package analog_pin_pkg;

    // Register byte addresses; one aligned word per register.
    localparam logic [11:0] ADDR_RELEASE_CH0_7   = 12'h000;
    localparam logic [11:0] ADDR_RELEASE_CH8_15  = 12'h004;
    localparam logic [11:0] ADDR_RELEASE_CH16_23 = 12'h008;

    // Register width and reset value.
    localparam int          REG_WIDTH   = 8;
    localparam logic [7:0]  RELEASE_RST = 8'h00;

    // Channel count and the first channel of each register.
    localparam int NUM_CHANNELS  = 24;
    localparam int NUM_REGS      = 3;
    localparam int BASE_CH0_7    = 0;
    localparam int BASE_CH8_15   = 8;
    localparam int BASE_CH16_23  = 16;

    // AHB-Lite transfer type encoding (bit 1 set means active).
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // Per-pin requests from the port logic, before the release is applied.
    typedef struct packed {
        logic [23:0] out_data;
        logic [23:0] out_drive;
        logic [23:0] pullup_req;
    } port_request_type;

    // Per-pin controls toward the pad, after the release is applied.
    typedef struct packed {
        logic [23:0] out_data;
        logic [23:0] out_oe_n;
        logic [23:0] pullup_en;
        logic [23:0] in_buf_en;
    } pad_control_type;

endpackage

// ==== verilog/adc_analog_pin_control.sv ====
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - Each release bit decides whether its pin stays with the port or goes to the analog input.
// - Bit n of the first register governs the pin of channel n, for channels 0 to 7.
// - Bit n of the second register governs the pin of channel n plus 8.
// - Bit n of the third register governs the pin of channel n plus 16.
// - A bit at 0 keeps port control of its pin and a bit at 1 removes it.
// - A released pin has its output buffer forced to high impedance.
// - A released pin has its input buffer off and port reads of it give zero.
// - A released pin has its pullup off even when the port asks for it.
module adc_analog_pin_control
(
    input  wire logic                             hclk,
    input  wire logic                             hresetn,
    input  wire logic                             hsel,
    input  wire logic [11:0]                      haddr,
    input  wire logic [1:0]                       htrans,
    input  wire logic                             hwrite,
    input  wire logic [2:0]                       hsize,
    input  wire logic [31:0]                      hwdata,
    input  wire logic                             hready,
    output logic      [31:0]                      hrdata,
    output logic                                  hreadyout,
    output logic                                  hresp,
    input  wire analog_pin_pkg::port_request_type port_req,
    input  wire logic [23:0]                      pad_in,
    output analog_pin_pkg::pad_control_type       pad_ctrl,
    output logic      [23:0]                      port_read_data,
    output logic      [23:0]                      analog_select
);

    // Which register an address selects; used by the write and read paths.
    // The compare is exact on the whole address, so a stray byte address or
    // an alias never reaches a register. The transfer size is ignored, since
    // software only ever moves whole words here.
    function automatic logic [2:0] reg_hit(input logic [11:0] addr);
        reg_hit = {addr == analog_pin_pkg::ADDR_RELEASE_CH16_23,
                   addr == analog_pin_pkg::ADDR_RELEASE_CH8_15,
                   addr == analog_pin_pkg::ADDR_RELEASE_CH0_7};
    endfunction

    logic        wr_pend_q;
    logic        wr_pend_d;
    logic [2:0]  wr_hit_q;
    logic [2:0]  wr_hit_d;
    logic [7:0]  release_q [3];
    logic [7:0]  release_d [3];
    logic [31:0] hrdata_q;
    logic [31:0] hrdata_d;
    logic [23:0] released;
    logic [23:0] pad_in_meta_q;
    logic [23:0] pad_in_sync_q;
    logic [23:0] pad_in_meta_d;
    logic [23:0] pad_in_sync_d;
    // One bit per pin for each gated control, filled by the per-pin copies.
    logic        pin_oe_n    [24];
    logic        pin_pull_en [24];
    logic        pin_in_en   [24];
    logic        pin_read    [24];
    logic        take;
    logic [2:0]  rd_hit;

    // The slave never stalls, so every data phase ends in one cycle.
    // Read data are taken at the address phase, so a read placed right
    // behind a write to the same register returns the old value; masters
    // that need the new value leave one idle cycle between the two.
    // The response is always OKAY, as nothing here can be refused.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;
    assign take      = hsel && hready && htrans[1];
    assign rd_hit    = reg_hit(haddr);

    // Address phase capture and register update from the data phase.
    // The write target is decoded in the address phase and kept, because
    // the address has already moved on when the write data arrive.
    // Only the low byte of the data is stored; the upper bits are dropped.
    always_comb
    begin
        wr_pend_d = take && hwrite;
        wr_hit_d  = take && hwrite ? reg_hit(haddr) : 3'h0;
        hrdata_d  = hrdata_q;
        for (int r = 0; r < 3; r++)
        begin
            release_d[r] = release_q[r];
            if (wr_pend_q && wr_hit_q[r])
            begin
                release_d[r] = hwdata[7:0];
            end
        end
        // Read data are latched at the address phase; unmapped reads give zero.
        if (take && !hwrite)
        begin
            hrdata_d = 32'h0000_0000;
            for (int r = 0; r < 3; r++)
            begin
                if (rd_hit[r])
                begin
                    hrdata_d = {24'h00_0000, release_q[r]};
                end
            end
        end
    end

    // Registers clear so every pin starts under port control.
    // A reset in mid-run therefore hands every pin back to the port at once,
    // and any write that was half way through is dropped.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_hit_q  <= 3'h0;
            hrdata_q  <= 32'h0000_0000;
            for (int r = 0; r < 3; r++)
            begin
                release_q[r] <= analog_pin_pkg::RELEASE_RST;
            end
        end
        else
        begin
            wr_pend_q <= wr_pend_d;
            wr_hit_q  <= wr_hit_d;
            hrdata_q  <= hrdata_d;
            for (int r = 0; r < 3; r++)
            begin
                release_q[r] <= release_d[r];
            end
        end
    end

    // Pad inputs come from outside the clock domain, so two flops stand
    // between the pins and any logic that reads them. Nothing but the
    // second stage is read; the first may still be settling.
    always_comb
    begin
        pad_in_meta_d = pad_in;
        pad_in_sync_d = pad_in_meta_q;
    end

    // The synchroniser costs two cycles of delay on port reads, which is
    // far below anything that software polling a pin can notice.
    // Both stages clear to zero, so port reads show low just after reset.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pad_in_meta_q <= 24'h00_0000;
            pad_in_sync_q <= 24'h00_0000;
        end
        else
        begin
            pad_in_meta_q <= pad_in_meta_d;
            pad_in_sync_q <= pad_in_sync_d;
        end
    end

    // Channel mapping: register r bit n serves channel 8*r + n.
    assign released[7:0]   = release_q[0];
    assign released[15:8]  = release_q[1];
    assign released[23:16] = release_q[2];

    // The converter side sees the release bits as they stand.
    // Bit k of this output belongs to channel k and nothing else.
    assign analog_select = released;

    // Per-pin gating, one copy for each channel.
    // The release is applied without a register, so a pin goes quiet in
    // the cycle in which its bit changes; a registered path would leave a
    // cycle in which the port could still fight the analog source.
    // A bit at 0 lets every port request through unchanged.
    for (genvar ch = 0; ch < 24; ch++)
    begin : g_pin
        // A released pin never drives, whatever the port asks for.
        // The enable is active low, so forcing it high floats the pin.
        assign pin_oe_n[ch] = ~port_req.out_drive[ch]
                            | released[ch];

        // A released pin keeps its pullup off so that it cannot load
        // the analog source, even when the port asks for the pullup.
        assign pin_pull_en[ch] = port_req.pullup_req[ch]
                               & ~released[ch];

        // The input buffer of a released pin is switched off, so a level
        // between the rails cannot make it draw current.
        assign pin_in_en[ch] = ~released[ch];

        // Port reads of a released pin give zero, whatever the pad shows.
        assign pin_read[ch] = pad_in_sync_q[ch]
                            & ~released[ch];
    end

    // Gather the per-pin results into the pad and port outputs.
    // Output data pass straight through; they only matter while the
    // buffer drives, and the enable above already decides that.
    always_comb
    begin
        pad_ctrl.out_data  = port_req.out_data;
        pad_ctrl.out_oe_n  = 24'h00_0000;
        pad_ctrl.pullup_en = 24'h00_0000;
        pad_ctrl.in_buf_en = 24'h00_0000;
        port_read_data     = 24'h00_0000;
        for (int ch = 0; ch < 24; ch++)
        begin
            pad_ctrl.out_oe_n[ch]  = pin_oe_n[ch];
            pad_ctrl.pullup_en[ch] = pin_pull_en[ch];
            pad_ctrl.in_buf_en[ch] = pin_in_en[ch];
            port_read_data[ch]     = pin_read[ch];
        end
    end

endmodule

// ==== dv/pin_release_monitor.sv ====
`timescale 1ns/1ps
module pin_release_monitor
(
    input wire logic                             hclk,
    input wire logic                             hresetn,
    input wire analog_pin_pkg::port_request_type port_req,
    input wire analog_pin_pkg::pad_control_type  pad_ctrl,
    input wire logic [23:0]                      port_read_data,
    input wire logic [23:0]                      analog_select
);
    // Short names; a set release bit must win over the drive and pullup requests.
    wire [23:0] r  = analog_select, oe = pad_ctrl.out_oe_n;
    wire [23:0] pu = pad_ctrl.pullup_en, dr = port_req.out_drive;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_hiz_rel: assert property ((oe & r) == r) else $error("oe");
    a_oe_port: assert property (!((oe^~dr)&~r)) else $error("oe");
    a_buf_off: assert property (pad_ctrl.in_buf_en == ~r)
        else $error("inbuf");
    a_pull_off: assert property (!(pu & r)) else $error("pu");
    a_pull_port: assert property (!((pu ^ port_req.pullup_req) & ~r))
        else $error("pu");
    a_read_zero: assert property (!(port_read_data & r))
        else $error("read");
    a_data_pass: assert property
        (pad_ctrl.out_data == port_req.out_data) else $error("data");
    a_reset_clear: assert property ($rose(hresetn) |-> r == 24'h0)
        else $error("reset");
endmodule
bind adc_analog_pin_control pin_release_monitor i_pin_release_monitor (.hclk,
    .hresetn, .port_req, .pad_ctrl, .port_read_data, .analog_select);

// ==== dv/port_side_model.sv ====
`timescale 1ns/1ps
module port_side_model
(
    output analog_pin_pkg::port_request_type port_req,
    output logic [23:0]                      pad_in
);
    // The port asks to drive and pull up every pin; every pad sits high.
    assign port_req = {24'h5aa53c, 24'hffffff, 24'hffffff};
    assign pad_in   = 24'hffffff;
endmodule

// ==== dv/adc_analog_pin_control_bench.sv ====
`timescale 1ns/1ps
module adc_analog_pin_control_bench;
    localparam logic [23:0] PAT = 24'hc35a81;
    logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, rdy;
    logic        resp;
    logic [1:0]  htrans = 2'h0;
    logic [11:0] haddr = 12'h000;
    logic [31:0] hwdata = 32'h0, q;
    logic [23:0] pad_in, rd, sel;
    int          num_errors = 0, num_checks = 0;
    analog_pin_pkg::port_request_type pr;
    analog_pin_pkg::pad_control_type  pc;
    // The slave's own ready is the bus ready, so the wait loops are real.
    adc_analog_pin_control i_adc_analog_pin_control (.hclk, .hresetn,
        .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(rdy), .hrdata(q), .hreadyout(rdy), .hresp(resp), .port_req(pr),
        .pad_in, .pad_ctrl(pc), .port_read_data(rd), .analog_select(sel));
    port_side_model i_port_side_model (.port_req(pr), .pad_in);
    // Bus clock, and a limit far beyond the few dozen cycles needed.
    initial forever #50 hclk = ~hclk;
    initial #20000 close_out(1);
    task automatic chk(input string n, input logic [31:0] e, s);
        num_checks++;
        num_errors += int'(s !== e);
        if (s !== e)
            $display("wrong value %s expected %h seen %h", n, e, s);
    endtask
    // Each phase is held until ready is sampled high at a rising edge.
    task automatic xfer(input logic w, input logic [11:0] a, logic [31:0] d);
        {htrans, haddr, hwrite} <= {2'h2, a, w};
        do @(posedge hclk); while (rdy !== 1'b1);
        {htrans, hwdata} <= {2'h0, d};
        do @(posedge hclk); while (rdy !== 1'b1);
    endtask
    // Writes with upper bits set, one idle cycle apart, then read all and a hole.
    task automatic release_pins;
        for (int i = 0; i < 3; i++)
            xfer(1, 12'(i * 4), {24'hffffff, PAT[i*8 +: 8]});
        repeat (3) @(posedge hclk);
        chk("select", PAT, sel);
        chk("oe_n", PAT, pc.out_oe_n);
        chk("port read", {8'h0, ~PAT}, rd);
        chk("input buffer", {8'h0, ~PAT}, pc.in_buf_en);
        chk("pullup", {8'h0, ~PAT}, pc.pullup_en);
        chk("out data", 24'h5aa53c, pc.out_data);
        for (int i = 0; i < 4; i++)
        begin
            xfer(0, 12'(i * 4), 0);
            chk("readback", i < 3 ? PAT[i*8 +: 8] : 8'h00, q);
            chk("response", 0, resp);
            chk("ready", 1, rdy);
        end
    endtask
    // A reset in mid-run hands every pin back; a zero write does so too.
    task automatic reset_again;
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("select after reset", 0, sel);
        xfer(1, 12'h004, 32'h0000_00ff);
        @(posedge hclk);
        chk("select one byte", 24'h00ff00, sel);
        xfer(1, 12'h004, 32'h0000_0000);
        @(posedge hclk);
        chk("select cleared", 0, sel);
        chk("port read cleared", 24'hffffff, rd);
        chk("oe_n cleared", 0, pc.out_oe_n);
    endtask
    task automatic close_out(input int late);
        num_errors += late;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Reset is held for three edges, then the scenario runs.
    initial
    begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        release_pins();
        reset_again();
        close_out(0);
    end
endmodule
